// [logic/tpwp_fifo.sv]
// Staging FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tpwp_fifo #(
  parameter int WIDTH = 69,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  tpwp_fifo_if.sink             in_port,
  output logic [WIDTH-1:0]      o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full          = (wr_ptr[AW] != rd_ptr[AW])
                         && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty         = (wr_ptr == rd_ptr);
  assign in_port.ready = !full;
  assign push          = in_port.valid && !full;
  assign pop           = !empty && i_ready;
  assign o_valid       = !empty;
  assign o_data        = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_port.data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : tpwp_fifo
`default_nettype wire

// [logic/tpwp_fifo_if.sv]
// Interface carrying words between the capture side and the staging FIFO
`timescale 1ns/1ps
`default_nettype none
interface tpwp_fifo_if #(parameter int WIDTH = 69);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src  (output data, output valid, input ready);
  modport sink (input data, input valid, output ready);
endinterface : tpwp_fifo_if
`default_nettype wire

// [logic/tpwp_pkg.sv]
// Package of constants for the transmit partition write port
package tpwp_pkg;
  localparam int WORD_W        = 64;
  localparam int PART_N        = 8;
  localparam int PART_AW       = 3;
  localparam int DEPTH_32      = 16;
  localparam int DEPTH_MULT    = 2;
  localparam int PART_DEPTH    = DEPTH_32 * DEPTH_MULT;
  localparam int LINE_AW       = 4;
  localparam int FIFO_DEPTH    = 16;
  localparam int ENTRY_W       = WORD_W + 2 + PART_AW;
  localparam int OCC_W         = 6;
  localparam logic [5:0] FILL_THRESHOLD_RESET = 6'h18;
  localparam logic [5:0] OCC_RESET            = 6'h00;
  localparam logic [3:0] LINE_RESET           = 4'h0;
  localparam logic       HALF_RESET           = 1'b0;
  localparam logic [2:0] SYNC_RESET           = 3'h0;
endpackage : tpwp_pkg

// [logic/tpwp_write_port.sv]
// Transmit partition write port with partitioned buffer and fill flags
// How it works
// - While service disable is high the scheduler stops reading the buffer.
// - Ports of a disabled buffer stay unserviced until disable drops again.
// - While disabled the link side is given idle words instead of data.
// - Writes to a disabled buffer still fill it and fill status stays correct.
// - The write clock is foreign and is synchronised and edge detected here.
// - The fill flag follows the partition chosen by the 3-bit select.
// - The fill flag goes high once occupancy passes the fill threshold.
// - The buffer holds up to eight partitions addressed by the select.
// - In 64-bit mode each partition is twice its 32-bit-mode depth.
// - Several logical ports may map onto one shared partition.
// - A write strobe captures the 64-bit word into the buffer.
// - An end of packet advances the write pointer to the next line.
`timescale 1ns/1ps
`default_nettype none
module tpwp_write_port (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_tx_write_clock,
  input  wire logic        i_word_write_strobe,
  input  wire logic [63:0] i_write_word,
  input  wire logic        i_packet_end_flag,
  input  wire logic        i_packet_abort_flag,
  input  wire logic [2:0]  i_partition_select,
  input  wire logic        i_buffer_service_disable,
  input  wire logic [5:0]  i_fill_threshold,
  input  wire logic        i_sched_read_req,
  input  wire logic [2:0]  i_sched_partition,
  output logic             o_partition_fill_flag,
  output logic             o_sched_valid,
  output logic             o_sched_idle,
  output logic [63:0]      o_sched_word,
  output logic             o_sched_end,
  output logic             o_sched_abort,
  output logic             o_write_ready
);
  localparam int EW = tpwp_pkg::ENTRY_W;
  localparam int MW = tpwp_pkg::WORD_W + 2;

  // Synchronisers for all foreign inputs
  logic [2:0]  clk_sync;
  logic        we_s1;
  logic        we_s2;
  logic [63:0] data_s1;
  logic [63:0] data_s2;
  logic [1:0]  flag_s1;
  logic [1:0]  flag_s2;
  logic [2:0]  sel_s1;
  logic [2:0]  sel_s2;
  logic        dis_s1;
  logic        dis_s2;
  logic        wclk_rise;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      clk_sync <= tpwp_pkg::SYNC_RESET;
    end else begin
      clk_sync <= {clk_sync[1:0], i_tx_write_clock};
    end
  end
  assign wclk_rise = clk_sync[1] && !clk_sync[2];

  always_ff @(posedge i_clock) begin
    we_s1   <= i_word_write_strobe;
    we_s2   <= we_s1;
    data_s1 <= i_write_word;
    data_s2 <= data_s1;
    flag_s1 <= {i_packet_end_flag, i_packet_abort_flag};
    flag_s2 <= flag_s1;
    sel_s1  <= i_partition_select;
    sel_s2  <= sel_s1;
    dis_s1  <= i_buffer_service_disable;
    dis_s2  <= dis_s1;
  end

  // Capture into staging FIFO on write clock edge
  tpwp_fifo_if #(.WIDTH(EW)) cap_if ();
  logic [EW-1:0] fifo_data;
  logic          fifo_valid;
  logic          fifo_ready;
  logic          abort_ok;

  assign abort_ok     = flag_s2[0] && flag_s2[1];
  assign cap_if.valid = wclk_rise && we_s2;
  assign cap_if.data  = {sel_s2, flag_s2[1], abort_ok, data_s2};

  tpwp_fifo #(.WIDTH(EW), .DEPTH(tpwp_pkg::FIFO_DEPTH)) u_fifo (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .in_port (cap_if.sink),
    .o_data  (fifo_data),
    .o_valid (fifo_valid),
    .i_ready (fifo_ready)
  );

  // Partitioned buffer storage
  logic [MW-1:0] buf_mem [tpwp_pkg::PART_N][tpwp_pkg::PART_DEPTH];
  logic [3:0]    wr_line [tpwp_pkg::PART_N];
  logic          wr_half [tpwp_pkg::PART_N];
  logic [3:0]    rd_line [tpwp_pkg::PART_N];
  logic          rd_half [tpwp_pkg::PART_N];
  logic [5:0]    occ     [tpwp_pkg::PART_N];
  logic [2:0]    wp;
  logic [2:0]    rp;
  logic          room;
  logic          do_write;
  logic          do_read;
  logic          f_end;

  assign wp         = fifo_data[EW-1 -: 3];
  assign f_end      = fifo_data[MW-1];
  assign room       = occ[wp] != 6'(tpwp_pkg::PART_DEPTH);
  assign fifo_ready = room;
  assign do_write   = fifo_valid && room;
  assign rp         = i_sched_partition;
  assign do_read    = i_sched_read_req && !dis_s2
                      && (occ[rp] != 6'h00);

  // Buffer write port
  always_ff @(posedge i_clock) begin
    if (do_write) begin
      buf_mem[wp][{wr_line[wp], wr_half[wp]}] <= fifo_data[MW-1:0];
    end
  end

  // Write pointer per partition
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      for (int p = 0; p < tpwp_pkg::PART_N; p++) begin
        wr_line[p] <= tpwp_pkg::LINE_RESET;
        wr_half[p] <= tpwp_pkg::HALF_RESET;
      end
    end else if (do_write) begin
      if (f_end || wr_half[wp]) begin
        wr_line[wp] <= wr_line[wp] + 4'h1;
        wr_half[wp] <= tpwp_pkg::HALF_RESET;
      end else begin
        wr_half[wp] <= 1'b1;
      end
    end
  end

  // Read pointer per partition
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      for (int p = 0; p < tpwp_pkg::PART_N; p++) begin
        rd_line[p] <= tpwp_pkg::LINE_RESET;
        rd_half[p] <= tpwp_pkg::HALF_RESET;
      end
    end else if (do_read) begin
      if (buf_mem[rp][{rd_line[rp], rd_half[rp]}][MW-1] || rd_half[rp]) begin
        rd_line[rp] <= rd_line[rp] + 4'h1;
        rd_half[rp] <= tpwp_pkg::HALF_RESET;
      end else begin
        rd_half[rp] <= 1'b1;
      end
    end
  end

  // Occupancy in slots, closed lines count in full
  logic [5:0] wr_cost;
  logic [5:0] rd_cost;
  assign wr_cost = (f_end && !wr_half[wp]) ? 6'h02 : 6'h01;
  assign rd_cost = (buf_mem[rp][{rd_line[rp], rd_half[rp]}][MW-1]
                    && !rd_half[rp]) ? 6'h02 : 6'h01;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      for (int p = 0; p < tpwp_pkg::PART_N; p++) begin
        occ[p] <= tpwp_pkg::OCC_RESET;
      end
    end else begin
      for (int p = 0; p < tpwp_pkg::PART_N; p++) begin
        occ[p] <= occ[p]
                  + ((do_write && wp == 3'(p)) ? wr_cost : 6'h00)
                  - ((do_read && rp == 3'(p)) ? rd_cost : 6'h00);
      end
    end
  end

  // Scheduler read side
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_sched_valid <= 1'b0;
      o_sched_idle  <= 1'b1;
      o_sched_word  <= 64'h0;
      o_sched_end   <= 1'b0;
      o_sched_abort <= 1'b0;
    end else begin
      o_sched_valid <= do_read;
      o_sched_idle  <= !do_read;
      if (do_read) begin
        {o_sched_end, o_sched_abort, o_sched_word}
          <= buf_mem[rp][{rd_line[rp], rd_half[rp]}];
      end else begin
        o_sched_word  <= 64'h0;
        o_sched_end   <= 1'b0;
        o_sched_abort <= 1'b0;
      end
    end
  end

  // Staging room seen by the writer
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_write_ready <= 1'b0;
    end else begin
      o_write_ready <= cap_if.ready;
    end
  end

  // Fill flag on write clock edges for the selected partition
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_partition_fill_flag <= 1'b0;
    end else if (wclk_rise) begin
      o_partition_fill_flag <= occ[sel_s2] > i_fill_threshold;
    end
  end
endmodule : tpwp_write_port
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the transmit partition write port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        i_clock = 1'b0;
  logic        i_reset = 1'b1;
  logic [2:0]  sel = 3'h0;
  logic [2:0]  sp = 3'h0;
  logic [5:0]  thr = 6'h3f;
  logic        dis = 1'b0;
  logic        req = 1'b0;
  logic        wclk, we, eop, abt, fl, v, idl, oe, oa, rdy;
  logic [63:0] wd, ow;
  int          n_fail = 0;
  int          check_count = 0;
  always #2.5 i_clock = ~i_clock;
  tpwp_user_model tpwp_user_model_inst (.o_clk(wclk), .o_we(we),
    .o_word(wd), .o_end(eop), .o_abort(abt));
  tpwp_write_port tpwp_write_port_inst (.i_clock(i_clock),
    .i_reset(i_reset), .i_tx_write_clock(wclk), .i_word_write_strobe(we),
    .i_write_word(wd), .i_packet_end_flag(eop), .i_packet_abort_flag(abt),
    .i_partition_select(sel), .i_buffer_service_disable(dis),
    .i_fill_threshold(thr), .i_sched_read_req(req),
    .i_sched_partition(sp), .o_partition_fill_flag(fl),
    .o_sched_valid(v), .o_sched_idle(idl), .o_sched_word(ow),
    .o_sched_end(oe), .o_sched_abort(oa), .o_write_ready(rdy));
  task automatic wrap_up;
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [63:0] s, e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t saw %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [2:0] p, input logic [63:0] d,
                    input logic e, a, w);
    @(posedge i_clock) sel <= p;
    #1;
    tpwp_user_model_inst.put(w, d, e, a);
    repeat (10) @(posedge i_clock);
    #1;
  endtask
  task automatic rv(input logic [2:0] p, input logic ev,
                    input logic [63:0] ew);
    @(posedge i_clock) begin
      req <= 1'b1;
      sp <= p;
    end
    @(posedge i_clock) req <= 1'b0;
    #1;
    chk(v, ev);
    chk(idl, !ev);
    chk(ow, ew);
  endtask
  task automatic t_rw;
    for (int p = 0; p < 8; p++) begin
      wr(3'(p), {3'(p), 4'h1}, 1'b0, 1'b0, 1'b1);
      wr(3'(p), {3'(p), 4'h2}, 1'b0, 1'b0, 1'b1);
    end
    for (int p = 0; p < 8; p++) begin
      rv(3'(p), 1'b1, {3'(p), 4'h1});
      rv(3'(p), 1'b1, {3'(p), 4'h2});
    end
    rv(3'h0, 0, 64'h0);
  endtask
  task automatic t_eop;
    @(posedge i_clock) thr <= 6'h1;
    wr(3'h3, 64'ha5, 1, 1, 1);
    wr(3'h3, 64'h0, 0, 0, 0);
    chk(fl, 1'b1);
    wr(3'h3, 64'h33, 0, 0, 1);
    rv(3'h3, 1, 64'ha5);
    chk(oe, 1'b1);
    chk(oa, 1'b1);
    rv(3'h3, 1, 64'h33);
    chk(oe, 1'b0);
    chk(oa, 1'b0);
  endtask
  task automatic t_dis;
    @(posedge i_clock) begin
      dis <= 1'b1;
      thr <= 6'h3;
    end
    for (int i = 0; i < 3; i++)
      wr(3'h5, 64'h50 + i, 0, 0, 1);
    wr(3'h5, 64'h0, 0, 0, 0);
    chk(fl, 1'b0);
    wr(3'h5, 64'h53, 0, 0, 1);
    wr(3'h5, 64'h0, 0, 0, 0);
    chk(fl, 1'b1);
    rv(3'h5, 0, 64'h0);
    wr(3'h6, 64'h0, 0, 0, 0);
    chk(fl, 1'b0);
    @(posedge i_clock) dis <= 1'b0;
    repeat (4) @(posedge i_clock);
    rv(3'h5, 1, 64'h50);
  endtask
  initial begin
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_clock);
    #1;
    chk(rdy, 1'b1);
    t_rw;
    t_eop;
    t_dis;
    wrap_up;
  end
  initial begin
    #20000;
    n_fail++;
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire

// [test/tpwp_user_model.sv]
// User side writer model making the foreign write clock
`timescale 1ns/1ps
`default_nettype none
module tpwp_user_model (
  output logic        o_clk,
  output logic        o_we,
  output logic [63:0] o_word,
  output logic        o_end,
  output logic        o_abort
);
  initial begin
    o_clk = 1'b0;
    o_we = 1'b0;
    o_word = 64'h0;
    o_end = 1'b0;
    o_abort = 1'b0;
  end
  // One 64 ns clock period per word, clock still between
  task automatic put(input logic w, input logic [63:0] d, input logic e, a);
    o_we = w;
    o_word = d;
    o_end = e;
    o_abort = a & e;
    #32 o_clk = 1'b1;
    #32 o_clk = 1'b0;
    o_we = 1'b0;
    o_word = ~d;
    o_end = ~e;
    o_abort = 1'b0;
  endtask
endmodule // tpwp_user_model
`default_nettype wire

// [test/tpwp_write_port_assertions.sv]
// Checker of scheduler outputs and fill flag timing
`timescale 1ns/1ps
`default_nettype none
module tpwp_write_port_assertions (
  input wire logic        i_clock,
  input wire logic        i_reset,
  input wire logic        i_tx_write_clock,
  input wire logic        i_buffer_service_disable,
  input wire logic        i_sched_read_req,
  input wire logic        o_partition_fill_flag,
  input wire logic        o_sched_valid,
  input wire logic        o_sched_idle,
  input wire logic [63:0] o_sched_word,
  input wire logic        o_sched_end,
  input wire logic        o_sched_abort
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  property p_dq; i_buffer_service_disable [*4] |=> !o_sched_valid; endproperty
  a_dq: assert property (p_dq) else $error("valid while disabled");
  property p_di; i_buffer_service_disable [*4] |=> o_sched_idle; endproperty
  a_di: assert property (p_di) else $error("no idle while disabled");
  property p_vr; o_sched_valid |-> $past(i_sched_read_req); endproperty
  a_vr: assert property (p_vr) else $error("valid without request");
  property p_vx; o_sched_valid |-> !o_sched_idle; endproperty
  a_vx: assert property (p_vx) else $error("valid and idle");
  property p_iz; o_sched_idle |-> o_sched_word == 64'h0; endproperty
  a_iz: assert property (p_iz) else $error("idle word not zero");
  property p_ae; o_sched_abort |-> o_sched_end; endproperty
  a_ae: assert property (p_ae) else $error("abort without end");
  property p_fs;
    !i_tx_write_clock [*8] |=> $stable(o_partition_fill_flag);
  endproperty
  a_fs: assert property (p_fs) else $error("flag moved off clock");
  property p_rs;
    $fell(i_reset) |-> o_sched_idle && !o_sched_valid;
  endproperty
  a_rs: assert property (p_rs) else $error("bad reset outputs");
endmodule // tpwp_write_port_assertions
bind tpwp_write_port tpwp_write_port_assertions
  tpwp_write_port_assertions_inst (
    .i_clock                  (i_clock),
    .i_reset                  (i_reset),
    .i_tx_write_clock         (i_tx_write_clock),
    .i_buffer_service_disable (i_buffer_service_disable),
    .i_sched_read_req         (i_sched_read_req),
    .o_partition_fill_flag    (o_partition_fill_flag),
    .o_sched_valid            (o_sched_valid),
    .o_sched_idle             (o_sched_idle),
    .o_sched_word             (o_sched_word),
    .o_sched_end              (o_sched_end),
    .o_sched_abort            (o_sched_abort)
  );
`default_nettype wire
